// file: core/twu_core.sv
// Two-wire master/slave controller with APB register access.
// Assumes open-drain SCL/SDA resolved outside; pin inputs are asynchronous and synchronised here.
//
// Behaviour
// - Clearing the event flag starts the next action; completion loads status and sets flag.
// - With acknowledge bit clear, own and general-call addresses are not acknowledged.
// - Start request waits for free bus, sends START, reports 08h.
// - Write-address acknowledge phase reports 18h or 20h; 38h from arbitration loss is loaded without the flag.
// - Repeated START reports 10h; direction follows next loaded address byte.
// - Read-address acknowledge phase reports 40h or 48h; 38h from arbitration loss is loaded without the flag.
// - Slave matches upper seven address bits; general call only when bit zero set.
// - Own address with read bit enters slave transmit and flags status.
// - Own address with write bit enters slave receive and flags status.
// - Arbitration loss moves to slave with B0h, 68h or 78h.
// - Acknowledge cleared in slave transmit: send last byte, report C0h/C8h, unaddress.
// - Acknowledge cleared: keep monitoring, ignore addresses; setting resumes recognition.
// - Acknowledge cleared in slave receive returns not-acknowledge after next byte.
// - Status reads F8h while event flag is clear.
// - START or STOP inside a byte or acknowledge is a bus error, 00h.
// - Recovery unaddresses, clears stop only, releases lines without STOP.
// - Seven-bit slave addressing.
// - Event flag stretches SCL low, never a high SCL.
// - Stop request in master sends STOP and clears bit once STOP seen.
// - Start request in master after bytes issues repeated START.
// - MSB first, sample on SCL rise, shift on fall, ninth clock is acknowledge.
`timescale 1ns/1ps
`include "twu_params.svh"
module twu_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output twu_pkg::twu_pins_t pins
);
  import twu_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic scl_d_ff, sda_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_ff <= 2'b11;
      sda_sy_ff <= 2'b11;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], scl_i};
      sda_sy_ff <= {sda_sy_ff[0], sda_i};
      scl_d_ff <= scl_sy_ff[1];
      sda_d_ff <= sda_sy_ff[1];
    end
  end
  wire scl_s = scl_sy_ff[1];
  wire sda_s = sda_sy_ff[1];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ----------------------------------------
  // Registers and engine state
  // ----------------------------------------
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] data_ff, nxt_data;
  logic [7:0] addr_ff, nxt_addr;
  twu_phase_t ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  logic master_ff, nxt_master;
  logic slave_ff, nxt_slave;      // Addressed slave
  logic tx_ff, nxt_tx;            // We drive data bits
  logic addr_ph_ff, nxt_addr_ph;  // Current byte is an address byte
  logic gc_ff, nxt_gc;
  logic busy_ff, nxt_busy;        // Bus between START and STOP
  logic bytes_ff, nxt_bytes;      // Master has moved a byte
  logic last_ff, nxt_last;        // Arbitration lost; selects 68h/78h/B0h at addressing
  logic sda_o_ff, nxt_sda_o;
  logic scl_o_ff, nxt_scl_o;
  logic [11:0] div_ff, nxt_div;
  logic [7:0] rx_ff, nxt_rx;

  wire en = ctrl_ff[`TWU_B_EN];
  wire si = ctrl_ff[`TWU_B_SI];
  wire aa = ctrl_ff[`TWU_B_AA];
  wire [2:0] rate = {ctrl_ff[`TWU_B_CR2], ctrl_ff[`TWU_B_CR1], ctrl_ff[`TWU_B_CR0]};
  wire [11:0] half_cyc = 12'(`TWU_HALF_CYC >> rate);
  wire tick = (div_ff == 12'h000);
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;

  // ----------------------------------------
  // Next-state logic: register writes and bus engine
  // ----------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_stat = stat_ff;
    nxt_data = data_ff;
    nxt_addr = addr_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_master = master_ff;
    nxt_slave = slave_ff;
    nxt_tx = tx_ff;
    nxt_addr_ph = addr_ph_ff;
    nxt_gc = gc_ff;
    nxt_busy = busy_ff;
    nxt_bytes = bytes_ff;
    nxt_last = last_ff;
    nxt_sda_o = sda_o_ff;
    nxt_scl_o = scl_o_ff;
    nxt_rx = rx_ff;
    nxt_div = tick ? half_cyc : div_ff - 12'h001;
    // Software writes first; hardware events below win over them
    if (wr_acc && paddr == `TWU_OFF_CTRL) nxt_ctrl = pwdata[7:0];
    if (wr_acc && paddr == `TWU_OFF_DATA && si) nxt_data = pwdata[7:0];
    if (wr_acc && paddr == `TWU_OFF_ADDR) nxt_addr = pwdata[7:0];
    if (start_det) nxt_busy = 1'b1;
    if (stop_det) nxt_busy = 1'b0;
    if (!en) begin
      // Disabled: released, unaddressed, stop bit forced low
      nxt_ctrl[`TWU_B_STO] = 1'b0;
      nxt_ph = TWU_IDLE;
      nxt_master = 1'b0;
      nxt_slave = 1'b0;
      nxt_sda_o = 1'b1;
      nxt_scl_o = 1'b1;
    end else if ((start_det || stop_det) && (ph_ff == TWU_BITS || ph_ff == TWU_ACK) && bit_ff != 4'h0
                 && !(master_ff && ph_ff == TWU_START)) begin
      nxt_stat = `TWU_S_BERR;
      nxt_ctrl[`TWU_B_SI] = 1'b1;
      nxt_ph = TWU_HOLD;
      nxt_master = 1'b0;
      nxt_sda_o = 1'b1;
      nxt_scl_o = 1'b1;
    end else if (si) begin
      // Flag set: keep SCL low if we hold it low, never pull a high SCL
      nxt_div = half_cyc;
    end else begin
      unique case (ph_ff)
        TWU_IDLE: begin
          if (ctrl_ff[`TWU_B_STO] && !master_ff) begin
            nxt_ctrl[`TWU_B_STO] = 1'b0;
            nxt_slave = 1'b0;
          end else if (ctrl_ff[`TWU_B_STA] && (!busy_ff || master_ff) && !start_det && tick) begin
            nxt_sda_o = 1'b0;
            nxt_ph = TWU_START;
          end else if (start_det) begin
            nxt_ph = TWU_BITS;
            nxt_bit = 4'hf; // The SCL fall that ends the START wraps this to zero
            nxt_addr_ph = 1'b1;
            nxt_tx = 1'b0;
          end
        end
        TWU_START: if (tick) begin
          // SCL falls after SDA: START complete
          nxt_scl_o = 1'b0;
          nxt_master = 1'b1;
          nxt_ctrl[`TWU_B_STA] = 1'b0;
          nxt_stat = bytes_ff ? `TWU_S_RSTART : `TWU_S_START;
          nxt_ctrl[`TWU_B_SI] = 1'b1;
          nxt_ph = TWU_HOLD;
          nxt_addr_ph = 1'b1;
        end
        TWU_HOLD: begin
          // Flag cleared by software: pick the next action
          if (ctrl_ff[`TWU_B_STO] && !master_ff) begin
            nxt_ctrl[`TWU_B_STO] = 1'b0;
            nxt_slave = 1'b0;
            nxt_ph = TWU_IDLE;
            nxt_sda_o = 1'b1;
            nxt_scl_o = 1'b1;
          end else if (master_ff && ctrl_ff[`TWU_B_STO]) begin
            nxt_sda_o = 1'b0;
            nxt_ph = TWU_STOP;
          end else if (master_ff && ctrl_ff[`TWU_B_STA] && !addr_ph_ff) begin
            nxt_sda_o = 1'b1;
            nxt_scl_o = 1'b1;
            nxt_ph = TWU_IDLE;
          end else if (!master_ff && !slave_ff) begin
            nxt_ph = TWU_IDLE;
          end else begin
            nxt_tx = master_ff ? (addr_ph_ff | ~data_ff[0] | tx_ff) & ~(~addr_ph_ff & ~tx_ff) : tx_ff;
            if (master_ff && addr_ph_ff) nxt_tx = 1'b1;
            nxt_bit = 4'h0;
            nxt_ph = TWU_BITS;
            nxt_sda_o = nxt_tx ? data_ff[7] : 1'b1;
            nxt_scl_o = master_ff ? 1'b0 : 1'b1;
          end
        end
        TWU_BITS, TWU_ACK: begin
          // Master clock generation with stretch support
          if (master_ff && tick && (nxt_scl_o == scl_s || !scl_o_ff)) nxt_scl_o = ~scl_o_ff;
          if (stop_det) begin
            nxt_ph = TWU_IDLE;
            nxt_slave = 1'b0;
          end else if (scl_rise) begin
            nxt_rx = {rx_ff[6:0], sda_s};
            if (ph_ff == TWU_BITS && master_ff && tx_ff && sda_o_ff && !sda_s) begin
              nxt_master = 1'b0;
              nxt_tx = 1'b0;
              nxt_sda_o = 1'b1;
              nxt_scl_o = 1'b1;
              nxt_stat = `TWU_S_ARB;
              nxt_last = 1'b1;
            end
          end else if (scl_fall) begin
            if (ph_ff == TWU_BITS && bit_ff == 4'h7) begin
              nxt_ph = TWU_ACK;
              nxt_data = rx_ff;
              // Address byte heard by a non-master: compare own or general call
              if (addr_ph_ff && !master_ff) begin
                nxt_gc = (rx_ff[7:1] == `TWU_GC_ADDR) && addr_ff[0];
                nxt_slave = aa && ((rx_ff[7:1] == addr_ff[7:1]) || nxt_gc);
              end
              if (tx_ff && !master_ff) nxt_sda_o = 1'b1;
              else if (!tx_ff) nxt_sda_o = ~(aa && (master_ff || nxt_slave));
              else nxt_sda_o = 1'b1;
            end else if (ph_ff == TWU_BITS) begin
              nxt_bit = bit_ff + 4'h1;
              nxt_sda_o = tx_ff ? data_ff[3'(3'h6 - bit_ff[2:0])] : 1'b1;
            end else begin
              // Ninth clock done: report and stretch if master or addressed slave, else release and go idle
              nxt_sda_o = 1'b1;
              nxt_scl_o = 1'b0;
              nxt_ph = TWU_HOLD;
              nxt_ctrl[`TWU_B_SI] = master_ff | slave_ff;
              if (master_ff) begin
                nxt_bytes = 1'b1;
                if (addr_ph_ff) nxt_stat = data_ff[0] ? (rx_ff[0] ? `TWU_S_AR_NAK : `TWU_S_AR_ACK)
                                                      : (rx_ff[0] ? `TWU_S_AW_NAK : `TWU_S_AW_ACK);
                else if (tx_ff) nxt_stat = rx_ff[0] ? `TWU_S_DW_NAK : `TWU_S_DW_ACK;
                else nxt_stat = aa ? `TWU_S_DR_ACK : `TWU_S_DR_NAK;
                if (addr_ph_ff) nxt_tx = ~data_ff[0];
                nxt_addr_ph = 1'b0;
              end else if (slave_ff && addr_ph_ff) begin
                nxt_tx = data_ff[0];
                nxt_last = ~aa;
                if (data_ff[0]) nxt_stat = last_ff ? `TWU_S_SR_ARB : `TWU_S_SR;
                else if (gc_ff) nxt_stat = last_ff ? `TWU_S_GC_ARB : `TWU_S_GC;
                else nxt_stat = last_ff ? `TWU_S_SW_ARB : `TWU_S_SW;
                nxt_addr_ph = 1'b0;
              end else if (slave_ff && tx_ff) begin
                nxt_stat = rx_ff[0] ? `TWU_S_ST_NAK : (aa ? `TWU_S_ST_ACK : `TWU_S_ST_LAST);
                if (rx_ff[0] || !aa) nxt_slave = 1'b0;
              end else if (slave_ff) begin
                nxt_stat = gc_ff ? (aa ? `TWU_S_GRD_ACK : `TWU_S_GRD_NAK)
                                 : (aa ? `TWU_S_SRD_ACK : `TWU_S_SRD_NAK);
                if (!aa) nxt_slave = 1'b0;
              end else begin
                nxt_ph = TWU_IDLE;
              end
              if (!(master_ff | slave_ff)) nxt_scl_o = 1'b1;
            end
          end
        end
        TWU_STOP: begin
          if (tick && !scl_o_ff) nxt_scl_o = 1'b1;
          else if (tick) nxt_sda_o = 1'b1;
          if (stop_det) begin
            nxt_ctrl[`TWU_B_STO] = 1'b0;
            nxt_master = 1'b0;
            nxt_bytes = 1'b0;
            nxt_ph = TWU_IDLE;
          end
        end
        default: nxt_ph = TWU_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `TWU_CTRL_RST;
      stat_ff <= `TWU_S_IDLE;
      data_ff <= `TWU_DATA_RST;
      addr_ff <= `TWU_ADDR_RST;
      ph_ff <= TWU_IDLE;
      bit_ff <= 4'h0;
      master_ff <= 1'b0;
      slave_ff <= 1'b0;
      tx_ff <= 1'b0;
      addr_ph_ff <= 1'b0;
      gc_ff <= 1'b0;
      busy_ff <= 1'b0;
      bytes_ff <= 1'b0;
      last_ff <= 1'b0;
      sda_o_ff <= 1'b1;
      scl_o_ff <= 1'b1;
      div_ff <= 12'h000;
      rx_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      data_ff <= nxt_data;
      addr_ff <= nxt_addr;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      master_ff <= nxt_master;
      slave_ff <= nxt_slave;
      tx_ff <= nxt_tx;
      addr_ph_ff <= nxt_addr_ph;
      gc_ff <= nxt_gc;
      busy_ff <= nxt_busy;
      bytes_ff <= nxt_bytes;
      last_ff <= nxt_last;
      sda_o_ff <= nxt_sda_o;
      scl_o_ff <= nxt_scl_o;
      div_ff <= nxt_div;
      rx_ff <= nxt_rx;
    end
  end

  // ----------------------------------------
  // APB read path and pins
  // ----------------------------------------
  // Zero wait states; unmapped reads give zero with no error
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr)
        `TWU_OFF_CTRL: prdata = {24'h000000, ctrl_ff};
        `TWU_OFF_STAT: prdata = {24'h000000, si ? stat_ff : `TWU_S_IDLE};
        `TWU_OFF_DATA: prdata = {24'h000000, data_ff};
        `TWU_OFF_ADDR: prdata = {24'h000000, addr_ff};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Drive only lows; a released line is pulled up outside
  assign pins.scl_o = 1'b0;
  assign pins.scl_oe = en & ~scl_o_ff;
  assign pins.sda_o = 1'b0;
  assign pins.sda_oe = en & ~sda_o_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_status_idle_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `TWU_OFF_STAT && !si) |-> prdata[7:0] == `TWU_S_IDLE)
    else $error("status not F8h while flag clear");
  a_disable_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> !ctrl_ff[`TWU_B_STO] && !pins.sda_oe)
    else $error("disabled unit holds stop or drives sda");
  a_berr_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (en && nxt_stat == `TWU_S_BERR && stat_ff != `TWU_S_BERR) |=> si && stat_ff == `TWU_S_BERR)
    else $error("bus error without flag");
  a_start_code: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !si && ph_ff == TWU_START && tick) |=> si && (stat_ff == `TWU_S_START || stat_ff == `TWU_S_RSTART))
    else $error("START not reported");
  a_flag_holds_scl: assert property (@(posedge pclk) disable iff (!presetn)
    (en && si && !scl_o_ff && ph_ff == TWU_HOLD) |=> !scl_o_ff)
    else $error("scl released while flag set");
  a_no_ack_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !si && !master_ff && !aa && addr_ph_ff && ph_ff == TWU_BITS && scl_fall && bit_ff == 4'h7)
    |=> !slave_ff && sda_o_ff)
    else $error("address acknowledged with acknowledge bit clear");
  a_stop_clears_sto: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !si && ph_ff == TWU_STOP && stop_det) |=> !ctrl_ff[`TWU_B_STO] && !master_ff)
    else $error("stop bit not cleared after STOP");
  a_arb_release: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !si && ph_ff == TWU_BITS && master_ff && tx_ff && sda_o_ff && scl_rise && !sda_s && !stop_det && !start_det)
    |=> !master_ff && sda_o_ff)
    else $error("arbitration loss not handled");
endmodule // twu_core

// file: core/twu_params.svh
// Constants for the two-wire unit: register offsets, control bit positions, status codes, timing.
// Assumes inclusion by bare name from the package and the core module.
`ifndef TWU_PARAMS_SVH
`define TWU_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TWU_OFF_CTRL 12'h000
`define TWU_OFF_STAT 12'h004
`define TWU_OFF_DATA 12'h008
`define TWU_OFF_ADDR 12'h00c
// ----------------------------------------
// Control bit positions and reset values
// ----------------------------------------
`define TWU_B_CR0 0
`define TWU_B_CR1 1
`define TWU_B_AA 2
`define TWU_B_SI 3
`define TWU_B_STO 4
`define TWU_B_STA 5
`define TWU_B_EN 6
`define TWU_B_CR2 7
`define TWU_CTRL_RST 8'h00
`define TWU_ADDR_RST 8'h00
`define TWU_DATA_RST 8'h00
// ----------------------------------------
// Status codes
// ----------------------------------------
`define TWU_S_BERR 8'h00
`define TWU_S_START 8'h08
`define TWU_S_RSTART 8'h10
`define TWU_S_AW_ACK 8'h18
`define TWU_S_AW_NAK 8'h20
`define TWU_S_DW_ACK 8'h28
`define TWU_S_DW_NAK 8'h30
`define TWU_S_ARB 8'h38
`define TWU_S_AR_ACK 8'h40
`define TWU_S_AR_NAK 8'h48
`define TWU_S_DR_ACK 8'h50
`define TWU_S_DR_NAK 8'h58
`define TWU_S_SW_ARB 8'h68
`define TWU_S_SW 8'h60
`define TWU_S_GC_ARB 8'h78
`define TWU_S_GC 8'h70
`define TWU_S_SRD_ACK 8'h80
`define TWU_S_SRD_NAK 8'h88
`define TWU_S_GRD_ACK 8'h90
`define TWU_S_GRD_NAK 8'h98
`define TWU_S_SSTOP 8'ha0
`define TWU_S_SR_ARB 8'hb0
`define TWU_S_SR 8'ha8
`define TWU_S_ST_ACK 8'hb8
`define TWU_S_ST_NAK 8'hc0
`define TWU_S_ST_LAST 8'hc8
`define TWU_S_IDLE 8'hf8
`define TWU_GC_ADDR 7'h00
// ----------------------------------------
// Timing: base half-period in pclk cycles (4.7 us at 200 MHz), divided by 2^rate
// ----------------------------------------
`define TWU_THALF_NS 4700
`define TWU_CLK_NS 5
`define TWU_HALF_CYC ((`TWU_THALF_NS + `TWU_CLK_NS - 1) / `TWU_CLK_NS)
`endif

// file: core/twu_pkg.sv
// Types shared by the two-wire unit.
// Assumes the params header is on the include path.
package twu_pkg;
  `include "twu_params.svh"
  // Engine phases
  typedef enum logic [2:0] {
    TWU_IDLE, TWU_START, TWU_BITS, TWU_ACK, TWU_HOLD, TWU_STOP
  } twu_phase_t;
  // Open-drain pin pair as seen at the core
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twu_pins_t;
endpackage

// file: verif/twu_bus_model.sv
// Far side of the two-wire bus: a slave that acks one address, and a master run by tasks.
// Assumes wired-AND lines with pull-ups; a device output enable high pulls the line low.
`timescale 1ns/1ps
module twu_bus_model #(
  parameter logic [6:0] SLV_ADDR = 7'h3c
) (
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  output logic scl,
  output logic sda
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  logic s_low = 1'b0;
  logic m_last = 1'b1;
  logic [7:0] s_sh = 8'h00;
  int s_cnt = 15;
  // Any low driver wins; released lines float to the pull-up
  assign scl = m_scl & ~dev_scl_oe;
  assign sda = m_sda & ~dev_sda_oe & ~s_low;
  // ----------------------------------------
  // Slave side
  // ----------------------------------------
  // START restarts the bit count, STOP parks it
  always @(sda) begin
    if (scl) begin
      s_cnt = sda ? 15 : 0;
    end
  end
  // Bits are taken on rising SCL, MSB first
  always @(posedge scl) begin
    if (s_cnt < 8) begin
      s_sh = {s_sh[6:0], sda};
    end
    if (s_cnt < 15) begin
      s_cnt = s_cnt + 1;
    end
  end
  // Ack only the own address, in the low phase before the ninth clock
  always @(negedge scl) begin
    s_low = (s_cnt == 8) && (s_sh[7:1] == SLV_ADDR);
  end
  // ----------------------------------------
  // Master side, 64 ns per bit
  // ----------------------------------------
  // Release SCL and wait out stretching; bounded so a stuck line cannot hang
  task automatic rise();
    int k;
    m_scl = 1'b1;
    k = 0;
    while (!scl && k < 2000) begin
      #4;
      k++;
    end
  endtask
  task automatic mstart();
    m_sda = 1'b1;
    rise();
    #32;
    m_sda = 1'b0;
    #32;
    m_scl = 1'b0;
  endtask
  // Data moves well after SCL falls so it is never mistaken for START or STOP
  task automatic mbit(input logic b);
    #8;
    m_sda = b;
    #24;
    rise();
    #32;
    m_last = sda;
    m_scl = 1'b0;
  endtask
  task automatic mstop();
    #8;
    m_sda = 1'b0;
    #24;
    rise();
    #32;
    m_sda = 1'b1;
    #32;
  endtask
endmodule // twu_bus_model

// file: verif/twu_core_tb.sv
// Bench for the two-wire unit: register table, master traffic, slave addressing, bus error.
// Assumes twu_bus_model as the far side of the bus and APB with no wait states expected.
`timescale 1ns/1ps
`include "twu_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module twu_core_tb;
  import twu_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  typedef struct packed { logic [11:0] a; logic [7:0] d; logic [7:0] e; } twu_row_t;
  typedef struct packed { logic [7:0] own; logic [7:0] ctl; logic [7:0] b; logic [7:0] st; logic ak; } twu_srow_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire scl;
  wire sda;
  twu_pins_t pins;
  logic [31:0] q;
  int n_errors = 0;
  int samples_checked = 0;
  twu_row_t rows [6] = '{'{`TWU_OFF_ADDR, 8'hb5, 8'hb5}, '{`TWU_OFF_CTRL, 8'h87, 8'h87},
    '{`TWU_OFF_STAT, 8'h55, 8'hf8}, '{`TWU_OFF_DATA, 8'h3c, 8'h00},
    '{12'h010, 8'hff, 8'h00}, '{`TWU_OFF_CTRL, 8'h00, 8'h00}};
  logic [7:0] m_dat [3] = '{8'h78, 8'h7a, 8'h79};
  logic [7:0] m_st [3] = '{`TWU_S_AW_ACK, `TWU_S_AW_NAK, `TWU_S_AR_ACK};
  // Ack clear row sits before a row that expects recognition back
  twu_srow_t srows [6] = '{'{8'hb4, 8'h44, 8'hb4, `TWU_S_SW, 1'b0}, '{8'hb4, 8'h40, 8'hb4, `TWU_S_IDLE, 1'b1},
    '{8'hb5, 8'h44, 8'hb5, `TWU_S_SR, 1'b0}, '{8'hb5, 8'h44, 8'h00, `TWU_S_GC, 1'b0},
    '{8'hb4, 8'h44, 8'h00, `TWU_S_IDLE, 1'b1}, '{8'hb4, 8'h44, 8'hb6, `TWU_S_IDLE, 1'b1}};
  always #2.5 pclk = ~pclk;
  twu_core i_twu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .pins(pins));
  twu_bus_model i_twu_bus_model (.dev_scl_oe(pins.scl_oe), .dev_sda_oe(pins.sda_oe), .scl(scl), .sda(sda));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One APB transfer; read data is taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // Poll control until the masked bits match; the bound stands in for a hang
  task automatic wait_ctrl(input logic [7:0] m, input logic [7:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, `TWU_OFF_CTRL, 8'h00);
      k++;
    end while ((q[7:0] & m) !== v && k < 400);
    if (k >= 400) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic stat_is(input logic [7:0] e);
    apb(1'b0, `TWU_OFF_STAT, 8'h00);
    `CHK(q[7:0], e)
  endtask
  task automatic send_addr(input logic [7:0] b);
    i_twu_bus_model.mstart();
    for (int j = 7; j >= 0; j--) begin
      i_twu_bus_model.mbit(b[j]);
    end
    i_twu_bus_model.mbit(1'b1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Register table: write, then read back what the register should hold
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      `CHK(q, {24'h0, rows[i].e})
    end
    // Master at the fastest rate: START, then three addresses joined by repeated STARTs
    apb(1'b1, `TWU_OFF_CTRL, 8'he3);
    wait_ctrl(8'h08, 8'h08);
    stat_is(`TWU_S_START);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        apb(1'b1, `TWU_OFF_CTRL, 8'he3);
        wait_ctrl(8'h08, 8'h08);
        stat_is(`TWU_S_RSTART);
      end
      apb(1'b1, `TWU_OFF_DATA, m_dat[i]);
      apb(1'b1, `TWU_OFF_CTRL, 8'hc3);
      wait_ctrl(8'h08, 8'h08);
      `CHK(scl, 1'b0)
      stat_is(m_st[i]);
    end
    apb(1'b1, `TWU_OFF_CTRL, 8'hd3);
    wait_ctrl(8'h10, 8'h00);
    stat_is(`TWU_S_IDLE);
    // Slave: the partner master addresses the device; stop request cleans up each row
    foreach (srows[i]) begin
      apb(1'b1, `TWU_OFF_ADDR, srows[i].own);
      apb(1'b1, `TWU_OFF_CTRL, srows[i].ctl);
      send_addr(srows[i].b);
      `CHK(i_twu_bus_model.m_last, srows[i].ak)
      if (srows[i].st !== `TWU_S_IDLE) begin
        wait_ctrl(8'h08, 8'h08);
      end
      stat_is(srows[i].st);
      apb(1'b1, `TWU_OFF_CTRL, srows[i].ctl | 8'h10);
      i_twu_bus_model.mstop();
      apb(1'b0, `TWU_OFF_CTRL, 8'h00);
      `CHK(q[7:0], srows[i].ctl)
    end
    // STOP inside an address byte, then recovery by stop request and flag clear
    i_twu_bus_model.mstart();
    for (int j = 2; j >= 0; j--) begin
      i_twu_bus_model.mbit(j[0]);
    end
    i_twu_bus_model.mstop();
    wait_ctrl(8'h08, 8'h08);
    stat_is(`TWU_S_BERR);
    apb(1'b1, `TWU_OFF_CTRL, 8'h54);
    apb(1'b0, `TWU_OFF_CTRL, 8'h00);
    `CHK(q[7:0], 8'h44)
    `CHK({scl, sda}, 2'b11)
    // Second reset in mid-run returns the registers to their reset values
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TWU_OFF_ADDR, 8'h00);
    `CHK(q[7:0], `TWU_ADDR_RST)
    apb(1'b0, `TWU_OFF_CTRL, 8'h00);
    `CHK(q[7:0], `TWU_CTRL_RST)
    stat_is(`TWU_S_IDLE);
    end_of_test();
  end
endmodule // twu_core_tb
